// *** src/debug_breakpoint_control.sv ***
// breakpoint control: break control register, four address match sets, halt sequencing
// assumes cpu fetch signals are on clk_i and the debug pins and link are asynchronous to it
`include "debug_breakpoint_control_map.svh"
`timescale 1ns/1ps
module debug_breakpoint_control
    import debug_breakpoint_pkg::*;
#(
    parameter int MATCH_SETS = 4
) (
    input wire logic clk_i,
    input wire logic rst_b_i,
    input wire logic link_clk_i,
    input wire logic link_rst_b_i,
    input wire logic link_wr_i,
    input wire debug_byte_t link_addr_i,
    input wire debug_byte_t link_data_i,
    output logic link_busy_o,
    input wire logic debug_clock_pin_i,
    input wire logic debug_data_pin_i,
    input wire logic fetch_valid_i,
    input wire logic first_opcode_i,
    input wire logic instr_done_i,
    input wire cpu_addr_t cpu_addr_i,
    output logic debug_halt_o,
    output logic step_break_request_o,
    output logic break_deferred_o,
    output logic [MATCH_SETS:0] break_source_o
);
    logic clk_pin_meta_ff;
    logic clk_pin_sync_ff;
    logic data_pin_meta_ff;
    logic data_pin_sync_ff;
    logic pins_low;
    logic strap_pend_ff;

    logic wr_pulse;
    debug_byte_t wr_addr;
    debug_byte_t wr_data;
    logic ctrl_we;
    logic match_we;
    logic [1:0] match_idx;
    logic [1:0] match_lane;

    debug_byte_t break_control_ff;
    cpu_addr_t match_addr_ff [MATCH_SETS];
    logic [MATCH_SETS-1:0] cmp_enable;
    logic [MATCH_SETS-1:0] cmp_page_only;
    logic [MATCH_SETS-1:0] cmp_hit;
    logic hit_now;
    logic boundary_fetch;
    logic step_set;
    logic resume_skip_ff;
    logic nxt_resume_skip;

    break_state_t state_ff;
    break_state_t nxt_state;
    logic halt_ff;
    logic deferred_ff;
    logic [MATCH_SETS:0] source_ff;
    logic [MATCH_SETS:0] nxt_source;

    // the debug pins are asynchronous; nothing reads the first stage except the second
    always_ff @(posedge clk_i) begin
        clk_pin_meta_ff <= debug_clock_pin_i;
        clk_pin_sync_ff <= clk_pin_meta_ff;
        data_pin_meta_ff <= debug_data_pin_i;
        data_pin_sync_ff <= data_pin_meta_ff;
    end

    assign pins_low = !clk_pin_sync_ff && !data_pin_sync_ff;

    // the strap is sampled on every edge held in reset and applied at the first edge after
    always_ff @(posedge clk_i) begin
        if (!rst_b_i) begin
            strap_pend_ff <= pins_low;
        end else begin
            strap_pend_ff <= 1'b0;
        end
    end

    debug_link_write_cdc u_link_write (
        .link_clk_i(link_clk_i),
        .link_rst_b_i(link_rst_b_i),
        .link_wr_i(link_wr_i),
        .link_addr_i(link_addr_i),
        .link_data_i(link_data_i),
        .link_busy_o(link_busy_o),
        .clk_i(clk_i),
        .rst_b_i(rst_b_i),
        .wr_pulse_o(wr_pulse),
        .wr_addr_o(wr_addr),
        .wr_data_o(wr_data)
    );

    // write-only space: nothing is returned, unmapped addresses and the fourth lane are ignored
    always_comb begin
        ctrl_we = 1'b0;
        match_we = 1'b0;
        match_idx = wr_addr[3:2];
        match_lane = wr_addr[1:0];
        if (!wr_pulse) begin
            ctrl_we = 1'b0;
        end else if (wr_addr == `BRK_CTRL_OFFSET) begin
            ctrl_we = 1'b1;
        end else if (wr_addr < `MATCH_LIMIT_OFFSET && wr_addr[1:0] != 2'h3) begin
            // match space starts at zero, so only the upper limit needs a compare
            match_we = 1'b1;
        end
    end

    // host writes store all bits; a hardware set of the step bit in the same edge wins
    always_ff @(posedge clk_i) begin
        if (!rst_b_i) begin
            break_control_ff <= `BRK_CTRL_RESET;
        end else begin
            if (ctrl_we) begin
                break_control_ff <= wr_data;
            end
            if (step_set) begin
                break_control_ff[`BIT_STEP_BREAK] <= 1'b1;
            end
        end
    end

    always_comb begin
        cmp_enable = '0;
        cmp_page_only = '0;
        cmp_enable[0] = break_control_ff[`BIT_MATCH0_EN];
        cmp_enable[1] = break_control_ff[`BIT_MATCH1_EN];
        cmp_enable[2] = break_control_ff[`BIT_MATCH2_EN];
        cmp_enable[3] = break_control_ff[`BIT_MATCH3_EN];
        cmp_page_only[0] = break_control_ff[`BIT_MATCH0_PAGE];
        cmp_page_only[1] = break_control_ff[`BIT_MATCH1_PAGE];
    end

    for (genvar g = 0; g < MATCH_SETS; g++) begin : gen_cmp
        always_ff @(posedge clk_i) begin
            if (!rst_b_i) begin
                match_addr_ff[g] <= `MATCH_RESET;
            end else if (match_we && match_idx == 2'(g)) begin
                if (match_lane == `MATCH_LANE_LOW) begin
                    match_addr_ff[g][7:0] <= wr_data;
                end else if (match_lane == `MATCH_LANE_HIGH) begin
                    match_addr_ff[g][15:8] <= wr_data;
                end else if (match_lane == `MATCH_LANE_UPPER) begin
                    match_addr_ff[g][23:16] <= wr_data;
                end
            end
        end

        // page-only drops the low byte from the compare, so any address in the 256-byte page hits
        assign cmp_hit[g] = fetch_valid_i && cmp_enable[g]
            && (cpu_addr_i[23:8] == match_addr_ff[g][23:8])
            && (cmp_page_only[g] || cpu_addr_i[7:0] == match_addr_ff[g][7:0]);
    end

    // right after a release the cpu refetches the halted instruction; skip one boundary so it runs
    assign hit_now = (|cmp_hit) && !resume_skip_ff;
    assign boundary_fetch = fetch_valid_i && first_opcode_i;

    always_comb begin
        nxt_state = state_ff;
        step_set = strap_pend_ff;
        nxt_source = source_ff;
        nxt_resume_skip = resume_skip_ff;
        case (state_ff)
            BRK_RUN: begin
                if (boundary_fetch && (break_control_ff[`BIT_STEP_BREAK] || hit_now)) begin
                    nxt_state = BRK_HALT;
                    step_set = 1'b1;
                    nxt_source = {cmp_hit & {MATCH_SETS{hit_now}}, break_control_ff[`BIT_STEP_BREAK]};
                    nxt_resume_skip = 1'b0;
                end else if (fetch_valid_i && !first_opcode_i && hit_now) begin
                    nxt_state = BRK_DEFER;
                    nxt_source = {cmp_hit, 1'b0};
                end else if (boundary_fetch) begin
                    nxt_resume_skip = 1'b0;
                end
            end
            BRK_DEFER: begin
                if (instr_done_i) begin
                    nxt_state = BRK_RUN;
                    step_set = 1'b1;
                end
            end
            BRK_HALT: begin
                if (!break_control_ff[`BIT_STEP_BREAK] && !step_set) begin
                    nxt_state = BRK_RUN;
                    nxt_resume_skip = 1'b1;
                end
            end
            default: begin
                nxt_state = BRK_RUN;
            end
        endcase
    end

    always_ff @(posedge clk_i) begin
        if (!rst_b_i) begin
            state_ff <= BRK_RUN;
            resume_skip_ff <= 1'b0;
        end else begin
            state_ff <= nxt_state;
            resume_skip_ff <= nxt_resume_skip;
        end
    end

    always_ff @(posedge clk_i) begin
        if (!rst_b_i) begin
            halt_ff <= 1'b0;
            deferred_ff <= 1'b0;
            source_ff <= '0;
        end else begin
            halt_ff <= (nxt_state == BRK_HALT);
            deferred_ff <= (nxt_state == BRK_DEFER);
            source_ff <= nxt_source;
        end
    end

    assign debug_halt_o = halt_ff;
    assign step_break_request_o = break_control_ff[`BIT_STEP_BREAK];
    assign break_deferred_o = deferred_ff;
    assign break_source_o = source_ff;
endmodule // debug_breakpoint_control

// *** src/debug_breakpoint_control_map.svh ***
// constants for the breakpoint control block: offsets, field positions, reset values
// assumes the includer uses them on 8-bit debug register addresses and data
// Function
// - break control sits at 10h, write-only, all eight bits reset to zero
// - bit 7 set halts the cpu on the next instruction; clear requests nothing
// - the next-instruction break fires only on the first opcode of an instruction
// - both debug pins low during reset set bit 7 and break on first instruction
// - bit 6 enables a full 24-bit address match against match set 3
// - bit 5 enables a full 24-bit address match against match set 2
// - the second comparator's enable allows a 24-bit match against match set 1
// - page-only on comparator 1 compares address bits 23 to 8 only
// - matches off an instruction start defer the halt until that instruction completes
// - a match break sets bit 7; the host clears bit 7 to release
// - a comparator whose enable bit is zero never causes a break
// - bit 4 enables comparator 0 against match set 0, with its page-only option
// - bit 2 selects page-only for comparator 1, bit 1 for comparator 0
// - match sets are low, high, upper bytes at 4n; set 0 at 00h, set 3 at 0Ch
`ifndef DEBUG_BREAKPOINT_CONTROL_MAP_SVH
`define DEBUG_BREAKPOINT_CONTROL_MAP_SVH

`define BRK_CTRL_OFFSET 8'h10
`define BRK_CTRL_RESET 8'h00
`define MATCH_BASE_OFFSET 8'h00
`define MATCH_LIMIT_OFFSET 8'h10
`define MATCH_LANE_LOW 2'h0
`define MATCH_LANE_HIGH 2'h1
`define MATCH_LANE_UPPER 2'h2
`define MATCH_RESET 24'h000000

`define BIT_STEP_BREAK 7
`define BIT_MATCH3_EN 6
`define BIT_MATCH2_EN 5
`define BIT_MATCH0_EN 4
`define BIT_MATCH1_EN 3
`define BIT_MATCH1_PAGE 2
`define BIT_MATCH0_PAGE 1

`endif

// *** src/debug_breakpoint_pkg.sv ***
// types shared by the breakpoint control block and its link write crossing
// assumes the map header supplies every numeric constant
package debug_breakpoint_pkg;
    typedef logic [7:0] debug_byte_t;
    typedef logic [23:0] cpu_addr_t;
    typedef enum logic [2:0] {
        BRK_RUN = 3'b001,
        BRK_DEFER = 3'b010,
        BRK_HALT = 3'b100
    } break_state_t;
endpackage

// *** src/debug_link_write_cdc.sv ***
// carries one register write from the debug link clock into the system clock
// assumes the link side holds link_wr_i only while link_busy_o is low for it to count
`timescale 1ns/1ps
module debug_link_write_cdc
    import debug_breakpoint_pkg::*;
(
    input wire logic link_clk_i,
    input wire logic link_rst_b_i,
    input wire logic link_wr_i,
    input wire debug_byte_t link_addr_i,
    input wire debug_byte_t link_data_i,
    output logic link_busy_o,
    input wire logic clk_i,
    input wire logic rst_b_i,
    output logic wr_pulse_o,
    output debug_byte_t wr_addr_o,
    output debug_byte_t wr_data_o
);
    logic req_tgl_ff;
    debug_byte_t hold_addr_ff;
    debug_byte_t hold_data_ff;
    logic ack_meta_ff;
    logic ack_sync_ff;
    logic busy_ff;
    logic accept;
    logic req_meta_ff;
    logic req_sync_ff;
    logic req_seen_ff;
    logic wr_pulse_ff;
    debug_byte_t wr_addr_ff;
    debug_byte_t wr_data_ff;

    // a write offered while busy is dropped; the held word must stay put until acknowledged
    assign accept = link_wr_i && !busy_ff;

    always_ff @(posedge link_clk_i) begin
        if (!link_rst_b_i) begin
            req_tgl_ff <= 1'b0;
            hold_addr_ff <= 8'h00;
            hold_data_ff <= 8'h00;
        end else if (accept) begin
            req_tgl_ff <= ~req_tgl_ff;
            hold_addr_ff <= link_addr_i;
            hold_data_ff <= link_data_i;
        end
    end

    always_ff @(posedge link_clk_i) begin
        if (!link_rst_b_i) begin
            ack_meta_ff <= 1'b0;
            ack_sync_ff <= 1'b0;
        end else begin
            ack_meta_ff <= req_seen_ff;
            ack_sync_ff <= ack_meta_ff;
        end
    end

    always_ff @(posedge link_clk_i) begin
        if (!link_rst_b_i) begin
            busy_ff <= 1'b0;
        end else begin
            busy_ff <= accept || (req_tgl_ff != ack_sync_ff);
        end
    end

    always_ff @(posedge clk_i) begin
        if (!rst_b_i) begin
            req_meta_ff <= 1'b0;
            req_sync_ff <= 1'b0;
        end else begin
            req_meta_ff <= req_tgl_ff;
            req_sync_ff <= req_meta_ff;
        end
    end

    // the held words are stable by the time the toggle has crossed, so they are read directly
    always_ff @(posedge clk_i) begin
        if (!rst_b_i) begin
            req_seen_ff <= 1'b0;
            wr_pulse_ff <= 1'b0;
            wr_addr_ff <= 8'h00;
            wr_data_ff <= 8'h00;
        end else begin
            wr_pulse_ff <= (req_sync_ff != req_seen_ff);
            req_seen_ff <= req_sync_ff;
            if (req_sync_ff != req_seen_ff) begin
                wr_addr_ff <= hold_addr_ff;
                wr_data_ff <= hold_data_ff;
            end
        end
    end

    assign link_busy_o = busy_ff;
    assign wr_pulse_o = wr_pulse_ff;
    assign wr_addr_o = wr_addr_ff;
    assign wr_data_o = wr_data_ff;
endmodule // debug_link_write_cdc

// *** tb/debug_host_model.sv ***
// debug host model: drives the link write port and both debug pins
// assumes the bench raises run during resets and calls write only when the link is idle
`timescale 1ns/1ps
module debug_host_model
    import debug_breakpoint_pkg::*;
(
    input wire logic link_busy_i,
    output logic link_clk_o,
    output logic link_wr_o,
    output debug_byte_t link_addr_o,
    output debug_byte_t link_data_o,
    output logic clock_pin_o,
    output logic data_pin_o
);
    logic run = 1'b1;
    logic strap = 1'b0;
    initial begin
        link_clk_o = 1'b0;
        link_wr_o = 1'b0;
        link_addr_o = 8'h5a;
        link_data_o = 8'ha5;
    end
    // link clock parks low between writes, as a real host leaves it
    always #3 if (run || link_clk_o) link_clk_o = ~link_clk_o;
    // pins idle high on pull-ups; both low only while strapping
    assign clock_pin_o = ~strap;
    assign data_pin_o = ~strap;
    task automatic write(input debug_byte_t ad, input debug_byte_t d, output bit ok);
        run = 1'b1;
        ok = 1'b0;
        @(posedge link_clk_o);
        link_wr_o <= 1'b1;
        link_addr_o <= ad;
        link_data_o <= d;
        @(posedge link_clk_o);
        link_wr_o <= 1'b0;
        link_addr_o <= ~ad;
        link_data_o <= ~d;
        for (int i = 0; i < 100 && !ok; i++) begin
            @(posedge link_clk_o);
            #1;
            ok = !link_busy_i;
        end
        run = 1'b0;
    endtask
endmodule // debug_host_model

// *** tb/debug_breakpoint_control_checker.sv ***
// concurrent checks on the halt, step and deferral outputs of the breakpoint block
// assumes a single system clock domain for everything watched here
`timescale 1ns/1ps
module debug_breakpoint_control_checker #(
    parameter int MATCH_SETS = 4
) (
    input wire logic clk_i,
    input wire logic rst_b_i,
    input wire logic fetch_valid_i,
    input wire logic first_opcode_i,
    input wire logic instr_done_i,
    input wire logic debug_halt_o,
    input wire logic step_break_request_o,
    input wire logic break_deferred_o,
    input wire logic [MATCH_SETS:0] break_source_o
);
    default clocking cb @(posedge clk_i); endclocking
    default disable iff (!rst_b_i);
    halt_needs_step_a: assert property ($rose(debug_halt_o) |-> step_break_request_o)
        else $error("halt rose without step bit");
    halt_holds_a: assert property (debug_halt_o && step_break_request_o |=> debug_halt_o)
        else $error("halt dropped while step bit set");
    step_boundary_a: assert property (step_break_request_o && fetch_valid_i && first_opcode_i
        && !debug_halt_o |=> debug_halt_o) else $error("no halt at boundary with step bit");
    halt_at_boundary_a: assert property ($rose(debug_halt_o) |-> $past(fetch_valid_i && first_opcode_i))
        else $error("halt not after boundary fetch");
    defer_cause_a: assert property ($rose(break_deferred_o) |-> $past(fetch_valid_i && !first_opcode_i))
        else $error("deferral without mid instruction fetch");
    defer_release_a: assert property (break_deferred_o && instr_done_i
        |=> !break_deferred_o && step_break_request_o) else $error("deferral not resolved at instruction end");
    halt_release_a: assert property (debug_halt_o && !step_break_request_o |=> !debug_halt_o)
        else $error("halt kept after step cleared");
    reset_clear_a: assert property (disable iff (1'b0) !rst_b_i
        |=> !debug_halt_o && !step_break_request_o && !break_deferred_o && break_source_o == '0)
        else $error("outputs not cleared by reset");
    cover property ($rose(debug_halt_o));
    cover property ($rose(break_deferred_o));
    cover property ($fell(debug_halt_o));
endmodule // debug_breakpoint_control_checker
bind debug_breakpoint_control debug_breakpoint_control_checker #(.MATCH_SETS(MATCH_SETS)) chk (.clk_i(clk_i),
    .rst_b_i(rst_b_i), .fetch_valid_i(fetch_valid_i), .first_opcode_i(first_opcode_i), .instr_done_i(instr_done_i),
    .debug_halt_o(debug_halt_o), .step_break_request_o(step_break_request_o), .break_deferred_o(break_deferred_o),
    .break_source_o(break_source_o));

// *** tb/debug_breakpoint_control_tb.sv ***
// self-checking bench: reference model of control and match registers against the block
// assumes debug_host_model drives the link and pins; link clock runs from each reset and around writes
`timescale 1ns/1ps
module debug_breakpoint_control_tb;
    import debug_breakpoint_pkg::*;
    logic clk = 1'b0, rst_b = 1'b0, link_rst_b = 1'b0, fetch_valid = 1'b0, first_opcode = 1'b0, instr_done = 1'b0;
    logic link_clk, link_wr, link_busy, clock_pin, data_pin, halt, step, deferred;
    debug_byte_t link_addr, link_data;
    cpu_addr_t cpu_addr = 24'h000000, a;
    logic [4:0] source;
    logic [23:0] m [4];
    int en_bit [4] = '{4, 3, 5, 6};
    int miscompares = 0, comparisons = 0, ctrl = 0;
    bit ok;
    always #12.5 clk = ~clk;
    debug_host_model host (.link_busy_i(link_busy), .link_clk_o(link_clk), .link_wr_o(link_wr),
        .link_addr_o(link_addr), .link_data_o(link_data), .clock_pin_o(clock_pin), .data_pin_o(data_pin));
    debug_breakpoint_control #(.MATCH_SETS(4)) dut (.clk_i(clk), .rst_b_i(rst_b), .link_clk_i(link_clk),
        .link_rst_b_i(link_rst_b), .link_wr_i(link_wr), .link_addr_i(link_addr), .link_data_i(link_data),
        .link_busy_o(link_busy), .debug_clock_pin_i(clock_pin), .debug_data_pin_i(data_pin),
        .fetch_valid_i(fetch_valid), .first_opcode_i(first_opcode), .instr_done_i(instr_done),
        .cpu_addr_i(cpu_addr), .debug_halt_o(halt), .step_break_request_o(step),
        .break_deferred_o(deferred), .break_source_o(source));
    task automatic stop_test();
        $display("comparisons %0d miscompares %0d", comparisons, miscompares);
        if (miscompares == 0 && comparisons > 0)
            $display("Testbench passed");
        else
            $display("Testbench failed");
        $finish;
    endtask
    task automatic chk_flag(logic got, logic exp);
        comparisons++;
        if (got !== exp) begin
            miscompares++;
            $display("mismatch at %0t: got %h expected %h", $time, got, exp);
        end
    endtask
    task automatic chk_src(logic [4:0] got, logic [4:0] exp);
        comparisons++;
        if (got !== exp) begin
            miscompares++;
            $display("mismatch at %0t: got %h expected %h", $time, got, exp);
        end
    endtask
    function automatic logic [4:0] hits(cpu_addr_t ad);
        hits = 5'h00;
        for (int k = 0; k < 4; k++)
            if (ctrl[en_bit[k]] && ad[23:8] == m[k][23:8] && ((k < 2 && ctrl[k + 1]) || ad[7:0] == m[k][7:0]))
                hits[k + 1] = 1'b1;
    endfunction
    // busy can fall a clock before the write lands; two clocks cover the landing and one state step
    task automatic wr(int ad, int d);
        host.write(8'(ad), 8'(d), ok);
        if (!ok) begin
            miscompares++;
            stop_test();
        end
        if (ad == 16)
            ctrl = d;
        else
            m[ad / 4][8 * (ad % 4) +: 8] = 8'(d);
        repeat (2) @(posedge clk);
        #1;
    endtask
    task automatic fetch(cpu_addr_t ad, logic first);
        @(posedge clk);
        fetch_valid <= 1'b1;
        first_opcode <= first;
        cpu_addr <= ad;
        @(posedge clk);
        fetch_valid <= 1'b0;
        first_opcode <= 1'b0;
        cpu_addr <= ~ad;
        #1;
    endtask
    task automatic do_reset(bit strap);
        host.strap = strap;
        host.run = 1'b1;
        @(posedge clk);
        rst_b <= 1'b0;
        link_rst_b <= 1'b0;
        repeat (20) @(posedge clk);
        rst_b <= 1'b1;
        link_rst_b <= 1'b1;
        @(posedge clk);
        #1;
        host.strap = 1'b0;
        ctrl = strap ? 8'h80 : 8'h00;
        chk_flag(step, strap);
        chk_flag(halt, 1'b0);
    endtask
    initial begin
        void'($urandom(32'h81670a1a));
        do_reset(1'b1);
        fetch(24'h000123, 1'b0);
        chk_flag(halt, 1'b0);
        fetch(24'h000124, 1'b1);
        chk_flag(halt, 1'b1);
        wr(16, 0);
        chk_flag(halt, 1'b0);
        do_reset(1'b0);
        for (int n = 0; n < 4; n++) begin
            a = 24'($urandom);
            for (int k = 0; k < 3; k++)
                wr(4 * n + k, a[8 * k +: 8]);
            fetch(a, 1'b1);
            chk_flag(halt, |hits(a));
            wr(16, 1 << en_bit[n]);
            fetch(a ^ 24'h000100, 1'b1);
            fetch(a ^ 24'h00005a, 1'b1);
            chk_flag(halt, |hits(a ^ 24'h00005a));
            fetch(a, 1'b1);
            chk_flag(halt, |hits(a));
            chk_src(source, hits(a));
            chk_flag(step, 1'b1);
            wr(16, (1 << en_bit[n]) | (n < 2 ? 2 << n : 0));
            fetch(a ^ 24'h000100, 1'b1);
            fetch(a ^ 24'h00005a, 1'b1);
            chk_flag(halt, |hits(a ^ 24'h00005a));
            wr(16, 1 << en_bit[n]);
            fetch(a ^ 24'h000100, 1'b1);
            fetch(a, 1'b0);
            chk_flag(deferred, 1'b1);
            @(posedge clk);
            instr_done <= 1'b1;
            @(posedge clk);
            instr_done <= 1'b0;
            #1;
            chk_flag(step, 1'b1);
            fetch(a ^ 24'h000100, 1'b1);
            chk_flag(halt, 1'b1);
            wr(16, 0);
        end
        stop_test();
    end
endmodule // debug_breakpoint_control_tb
